// ### hw/anm_monitor.sv
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "anm_params.svh"
// Function
// - Run negotiation at power-up and on request
// - Any reset idles machines, clears progress bits
// - Restart reinitialises machines, keeps progress bits
// - After restart bits change on read/reset/higher
// - After completion only read or reset alter
// - Link failure restarts negotiation, both modes
// - Restart bit triggers restart in software mode only (pin low), self-clears
// - Enable bit one-zero-one triggers restart in software mode only (pin low)
// - Select pin one-zero-one triggers restart in hardware mode only (pin high)
// - Negotiation typically finishes within 500 ms
// - Fast poll shows speed, duplex, link, done
// - Progress code is bits 4,13,12,11
// - Only codes 0h to 8h and Fh
// - Load code only when greater than held
// - Read loads present code if legal, even if lower
// - Read returns value latched before it
// - First read after completion gives 1 and 111
// - Later reads give 1 and 000b
// - Completion sets done in both status registers
module anm_monitor
#(
   parameter int unsigned AN_TIME_CYC = `ANM_AN_TIME_MS * `ANM_CLK_KHZ
)
(
   // Clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   rst_i,
   // Register port
   input  wire anm_pkg::anm_bus_req_t  bus_req_i,
   output logic [15:0]                 bus_rdata_o,
   // Pins
   input  wire logic                   hw_mode_pin_i,
   input  wire logic                   negotiation_select_pin_i,
   // Link monitor and arbitration engine
   input  wire logic                   link_ok_i,
   input  wire anm_pkg::anm_arb_stat_t arb_stat_i,
   output logic                        arb_restart_o,
   output logic                        arb_enable_o,
   // Status
   output logic                        an_done_o,
   output logic                        an_overdue_o
);
   import anm_pkg::*;

   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic code_legal(input logic [3:0] c);
      code_legal = (c <= `ANM_CODE_MAXSTEP) || (c == `ANM_CODE_DONE);
   endfunction

   function automatic logic is_rd(input anm_bus_req_t r,
                                  input logic [4:0] a);
      is_rd = r.rd && (r.addr == a);
   endfunction

   // ****************************************************
   // Declarations
   // ****************************************************
   logic        hwm_meta_reg;
   logic        hwm_sync_reg;
   logic        sel_meta_reg;
   logic        sel_sync_reg;
   logic        sel_last_reg;
   logic        link_last_reg;
   logic        en_last_reg;
   logic        ctrl_en_reg;
   logic        ctrl_restart_reg;
   logic        srst_reg;
   logic        restart_reg;
   anm_state_t  state_reg;
   anm_state_t  state_next;
   logic        done_reg;
   logic [3:0]  prog_reg;
   logic [15:0] rdata_reg;
   logic [31:0] timer_reg;
   logic        overdue_reg;
   logic        wr_ctrl;
   logic        rd_fpoll;
   logic        an_enabled;
   logic        restart_req;
   logic        clr_all;
   logic [3:0]  code_now;

   assign wr_ctrl  = bus_req_i.wr && (bus_req_i.addr == `ANM_REG_CTRL);
   assign rd_fpoll = is_rd(bus_req_i, `ANM_REG_FPOLL);
   assign code_now = arb_stat_i.code;

   // Software and hardware resets act alike on this block.
   assign clr_all  = srst_reg;

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hwm_meta_reg <= 1'b0;
         hwm_sync_reg <= 1'b0;
      end
      else
      begin
         hwm_meta_reg <= hw_mode_pin_i;
         hwm_sync_reg <= hwm_meta_reg;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sel_meta_reg <= 1'b0;
         sel_sync_reg <= 1'b0;
      end
      else
      begin
         sel_meta_reg <= negotiation_select_pin_i;
         sel_sync_reg <= sel_meta_reg;
      end
   end

   // ****************************************************
   // Control register
   // ****************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_en_reg      <= `ANM_CTRL_EN_RST;
         ctrl_restart_reg <= 1'b0;
         srst_reg         <= 1'b0;
      end
      else if (clr_all)
      begin
         ctrl_en_reg      <= `ANM_CTRL_EN_RST;
         ctrl_restart_reg <= 1'b0;
         srst_reg         <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         ctrl_en_reg      <= bus_req_i.wdata[`ANM_CTRL_EN];
         ctrl_restart_reg <= bus_req_i.wdata[`ANM_CTRL_RESTART];
         srst_reg         <= bus_req_i.wdata[`ANM_CTRL_SRST];
      end
      else
      begin
         // The restart bit is consumed the cycle after it is set.
         ctrl_restart_reg <= 1'b0;
      end
   end

   assign an_enabled = hwm_sync_reg ? sel_sync_reg : ctrl_en_reg;

   // ****************************************************
   // Edge history for restart detection
   // ****************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sel_last_reg  <= 1'b0;
         // Matches the enable reset value, so release is not an edge.
         en_last_reg   <= `ANM_CTRL_EN_RST;
         link_last_reg <= 1'b0;
      end
      else
      begin
         sel_last_reg  <= sel_sync_reg;
         en_last_reg   <= ctrl_en_reg;
         link_last_reg <= link_ok_i;
      end
   end

   // A rising enable edge ends a one-zero-one toggle; the falling
   // half alone merely parks the supervisor in idle.
   always_comb
   begin
      restart_req = 1'b0;
      if (link_last_reg && !link_ok_i)
      begin
         restart_req = 1'b1;
      end
      if (!hwm_sync_reg)
      begin
         if (ctrl_restart_reg)
         begin
            restart_req = 1'b1;
         end
         if (ctrl_en_reg && !en_last_reg)
         begin
            restart_req = 1'b1;
         end
      end
      else if (sel_sync_reg && !sel_last_reg)
      begin
         restart_req = 1'b1;
      end
   end

   // ****************************************************
   // Negotiation supervisor
   // ****************************************************
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ANM_ST_IDLE:
         begin
            if (an_enabled)
            begin
               state_next = ANM_ST_RUN;
            end
         end
         ANM_ST_RUN:
         begin
            if (code_now == `ANM_CODE_DONE)
            begin
               state_next = ANM_ST_DONE;
            end
         end
         ANM_ST_DONE:
         begin
            state_next = ANM_ST_DONE;
         end
         default:
         begin
            state_next = ANM_ST_IDLE;
         end
      endcase
      if (!an_enabled || restart_req)
      begin
         state_next = ANM_ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_reg <= ANM_ST_IDLE;
      end
      else if (clr_all)
      begin
         state_reg <= ANM_ST_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // The engine is told to reinitialise on every entry to run.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         restart_reg <= 1'b0;
      end
      else
      begin
         restart_reg <= (state_reg == ANM_ST_IDLE) && an_enabled
                        && !restart_req && !clr_all;
      end
   end

   // ****************************************************
   // Completion flag
   // ****************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         done_reg <= 1'b0;
      end
      else if (clr_all || restart_req || !an_enabled)
      begin
         done_reg <= 1'b0;
      end
      else if (state_reg == ANM_ST_RUN && code_now == `ANM_CODE_DONE)
      begin
         done_reg <= 1'b1;
      end
   end

   // ****************************************************
   // Progress latch
   // ****************************************************
   // Restarts never touch this latch, so software can still see
   // how far the previous attempt got.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prog_reg <= `ANM_CODE_RST;
      end
      else if (clr_all)
      begin
         prog_reg <= `ANM_CODE_RST;
      end
      else if (rd_fpoll)
      begin
         if (code_legal(code_now))
         begin
            prog_reg <= code_now;
         end
      end
      else if (state_reg == ANM_ST_RUN && code_legal(code_now)
               && code_now > prog_reg)
      begin
         prog_reg <= code_now;
      end
   end

   // ****************************************************
   // Typical-duration watchdog
   // ****************************************************
   // Overrun is only reported; the figure is typical, not a limit.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         timer_reg   <= 32'h0000_0000;
         overdue_reg <= 1'b0;
      end
      else if (clr_all || state_reg != ANM_ST_RUN)
      begin
         timer_reg   <= 32'h0000_0000;
         overdue_reg <= 1'b0;
      end
      else if (timer_reg >= AN_TIME_CYC - 1)
      begin
         overdue_reg <= 1'b1;
      end
      else
      begin
         timer_reg <= timer_reg + 32'h0000_0001;
      end
   end

   // ****************************************************
   // Read data
   // ****************************************************
   // The old latch value is captured here in the same edge that
   // the latch reloads, so a read sees the earlier value.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_reg <= 16'h0000;
      end
      else
      begin
         rdata_reg <= 16'h0000;
         if (bus_req_i.rd)
         begin
            case (bus_req_i.addr)
               `ANM_REG_CTRL:
               begin
                  rdata_reg[`ANM_CTRL_EN]      <= ctrl_en_reg;
                  rdata_reg[`ANM_CTRL_RESTART] <= ctrl_restart_reg;
                  rdata_reg[`ANM_CTRL_SRST]    <= srst_reg;
               end
               `ANM_REG_BSTAT:
               begin
                  rdata_reg[`ANM_BSTAT_DONE] <= done_reg;
                  rdata_reg[`ANM_BSTAT_LINK] <= link_ok_i;
               end
               `ANM_REG_FPOLL:
               begin
                  rdata_reg[`ANM_FP_SPEED]  <= arb_stat_i.speed_100;
                  rdata_reg[`ANM_FP_DUPLEX] <= arb_stat_i.full_duplex;
                  rdata_reg[`ANM_FP_PROG_HI:`ANM_FP_PROG_LO]
                     <= prog_reg[2:0];
                  rdata_reg[`ANM_FP_DONE]   <= prog_reg[3];
                  rdata_reg[`ANM_FP_LINK]   <= link_ok_i;
               end
               default:
               begin
                  rdata_reg <= 16'h0000;
               end
            endcase
         end
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign bus_rdata_o   = rdata_reg;
   assign arb_restart_o = restart_reg;
   assign arb_enable_o  = (state_reg != ANM_ST_IDLE);
   assign an_done_o     = done_reg;
   assign an_overdue_o  = overdue_reg;

endmodule

// ### pkg/anm_params.svh
`ifndef ANM_PARAMS_SVH
`define ANM_PARAMS_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define ANM_REG_CTRL      5'h00
`define ANM_REG_BSTAT     5'h01
`define ANM_REG_FPOLL     5'h11

// ****************************************************
// Field positions
// ****************************************************
`define ANM_CTRL_SRST     15
`define ANM_CTRL_EN       12
`define ANM_CTRL_RESTART  9
`define ANM_BSTAT_DONE    5
`define ANM_BSTAT_LINK    2
`define ANM_FP_SPEED      15
`define ANM_FP_DUPLEX     14
`define ANM_FP_PROG_HI    13
`define ANM_FP_PROG_LO    11
`define ANM_FP_DONE       4
`define ANM_FP_LINK       0

// ****************************************************
// Reset values and codes
// ****************************************************
`define ANM_CTRL_EN_RST   1'b1
`define ANM_CODE_RST      4'h0
`define ANM_CODE_MAXSTEP  4'h8
`define ANM_CODE_DONE     4'hF

// ****************************************************
// Timing
// ****************************************************
`define ANM_AN_TIME_MS    500
`define ANM_CLK_KHZ       125000

`endif

// ### pkg/anm_pkg.sv
package anm_pkg;

   // Supervisor states, Gray coded along idle, run, done.
   typedef enum logic [1:0]
   {
      ANM_ST_IDLE = 2'b00,
      ANM_ST_RUN  = 2'b01,
      ANM_ST_DONE = 2'b11
   } anm_state_t;

   // Register port request.
   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } anm_bus_req_t;

   // Report from the arbitration engine.
   typedef struct packed
   {
      logic [3:0] code;
      logic       speed_100;
      logic       full_duplex;
   } anm_arb_stat_t;

endpackage

// ### tb/anm_arb_model.sv
`timescale 1ns/10ps
module anm_arb_model
(
   // Clock and reset
   input  wire logic            sys_clk_i,
   input  wire logic            rst_i,
   // Control from the monitor and the bench
   input  wire logic            restart_i,
   input  wire logic            enable_i,
   input  wire logic            hold_i,
   input  wire logic [3:0]      target_i,
   // Report
   output anm_pkg::anm_arb_stat_t stat_o
);
   import anm_pkg::*;
   logic [3:0] code_reg;
   logic       seen_reg;
   // ****************************************************
   // Engine: climbs one code a cycle; hold_i stalls it.
   // ****************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         code_reg <= 4'h0;
         seen_reg <= 1'b0;
      end
      else if (restart_i)
      begin
         code_reg <= 4'h0;
         seen_reg <= 1'b0;
      end
      else if (enable_i && !hold_i)
      begin
         if (code_reg == 4'hF)
            code_reg <= 4'h8;
         else if (target_i == 4'hF && code_reg == 4'h8 && !seen_reg)
         begin
            code_reg <= 4'hF;
            seen_reg <= 1'b1;
         end
         else if (code_reg < target_i && code_reg < 4'h8)
            code_reg <= code_reg + 4'h1;
      end
   end
   assign stat_o = '{code: code_reg, speed_100: 1'b1, full_duplex: seen_reg};
endmodule

// ### tb/anm_monitor_sva.sv
`timescale 1ns/10ps
module anm_monitor_sva
(
   // Clock and reset
   input wire logic                   sys_clk_i,
   input wire logic                   rst_i,
   // Register port
   input wire anm_pkg::anm_bus_req_t  bus_req_i,
   input wire logic [15:0]            bus_rdata_o,
   // Pins and engine
   input wire logic                   hw_mode_pin_i,
   input wire logic                   negotiation_select_pin_i,
   input wire logic                   link_ok_i,
   input wire anm_pkg::anm_arb_stat_t arb_stat_i,
   input wire logic                   arb_restart_o,
   input wire logic                   arb_enable_o,
   input wire logic                   an_done_o
);
   import anm_pkg::*;
   logic rd17;
   logic wr0;
   assign rd17 = bus_req_i.rd && bus_req_i.addr == 5'h11;
   assign wr0 = bus_req_i.wr && bus_req_i.addr == 5'h00
                && !bus_req_i.wdata[15] && !hw_mode_pin_i;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   // A restart always passes through idle before the engine is started.
   sequence s_restart;
      !arb_enable_o ##1 arb_restart_o;
   endsequence
   property p_rd_idle;
      !$past(bus_req_i.rd) |-> bus_rdata_o == 16'h0000;
   endproperty
   property p_rd_live;
      rd17 |=> bus_rdata_o[15:14] == $past({arb_stat_i.speed_100,
         arb_stat_i.full_duplex}) && bus_rdata_o[0] == $past(link_ok_i);
   endproperty
   property p_rd_basic;
      bus_req_i.rd && bus_req_i.addr == 5'h01 |=> bus_rdata_o ==
         {10'h000, $past(an_done_o), 2'b00, $past(link_ok_i), 2'b00};
   endproperty
   property p_unmapped;
      bus_req_i.rd && !(bus_req_i.addr inside {5'h00, 5'h01, 5'h11})
         |=> bus_rdata_o == 16'h0000;
   endproperty
   property p_pulse;
      arb_restart_o |=> !arb_restart_o;
   endproperty
   property p_restart_bit;
      wr0 && bus_req_i.wdata[9] && bus_req_i.wdata[12] |-> ##[1:2] s_restart;
   endproperty
   property p_enable_off;
      wr0 && !bus_req_i.wdata[12] |-> ##[1:2] !arb_enable_o;
   endproperty
   property p_link_fail;
      $fell(link_ok_i) && arb_enable_o && !bus_req_i.wr
         |-> ##[1:2] s_restart;
   endproperty
   property p_pin_off;
      hw_mode_pin_i && $fell(negotiation_select_pin_i)
         |-> ##[1:5] !arb_enable_o;
   endproperty
   property p_done;
      arb_enable_o && link_ok_i && arb_stat_i.code == 4'hF
         && !bus_req_i.wr |=> an_done_o;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
   a_rd_live: assert property (p_rd_live) else $error("live bits");
   a_rd_basic: assert property (p_rd_basic) else $error("basic bits");
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   a_pulse: assert property (p_pulse) else $error("long pulse");
   a_restart_bit: assert property (p_restart_bit) else $error("rst bit");
   a_enable_off: assert property (p_enable_off) else $error("en off");
   a_link_fail: assert property (p_link_fail) else $error("link fail");
   a_pin_off: assert property (p_pin_off) else $error("pin off");
   a_done: assert property (p_done) else $error("done missing");
endmodule
bind anm_monitor anm_monitor_sva u_sva
(
   .sys_clk_i(sys_clk_i),
   .rst_i(rst_i),
   .bus_req_i(bus_req_i),
   .bus_rdata_o(bus_rdata_o),
   .hw_mode_pin_i(hw_mode_pin_i),
   .negotiation_select_pin_i(negotiation_select_pin_i),
   .link_ok_i(link_ok_i),
   .arb_stat_i(arb_stat_i),
   .arb_restart_o(arb_restart_o),
   .arb_enable_o(arb_enable_o),
   .an_done_o(an_done_o)
);

// ### tb/autoneg_restart_progress_monitor_tb.sv
`timescale 1ns/10ps
module autoneg_restart_progress_monitor_tb;
   import anm_pkg::*;
   logic            sys_clk_i;
   logic            rst_i;
   anm_bus_req_t    req;
   logic [15:0]     rdata;
   logic            hw_mode;
   logic            sel_pin;
   logic            link_ok;
   anm_arb_stat_t   arb_stat;
   logic            restart;
   logic            enable;
   logic            done;
   logic            overdue;
   logic            hold;
   logic [3:0]      target;
   int              n_errors;
   int              n_tests;
   // Short overdue count keeps the run brief.
   anm_monitor #(.AN_TIME_CYC(50)) DUT
   (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(req),
      .bus_rdata_o(rdata), .hw_mode_pin_i(hw_mode),
      .negotiation_select_pin_i(sel_pin), .link_ok_i(link_ok),
      .arb_stat_i(arb_stat), .arb_restart_o(restart),
      .arb_enable_o(enable), .an_done_o(done), .an_overdue_o(overdue)
   );
   anm_arb_model u_arb
   (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .restart_i(restart),
      .enable_i(enable), .hold_i(hold), .target_i(target),
      .stat_o(arb_stat)
   );
   initial
   begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // ****************************************************
   // Tasks
   // ****************************************************
   task automatic tally_and_finish();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge sys_clk_i);
      req.wr <= 1'b0;
   endtask
   // Called at an edge; the data are taken at the edge that ends
   // the cycle in which they stand, before the design clears them.
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge sys_clk_i);
      req.rd <= 1'b0;
      @(posedge sys_clk_i);
      chk(rdata, exp);
   endtask
   // A missing restart pulse ends the run at once.
   task automatic wait_restart(input int n);
      bit seen;
      seen = 1'b0;
      for (int i = 0; i < n && !seen; i++)
      begin
         @(posedge sys_clk_i);
         seen = (restart === 1'b1);
      end
      n_tests++;
      if (!seen)
      begin
         n_errors++;
         $display("[FAIL] %0t no restart pulse", $time);
         tally_and_finish();
      end
   endtask
   // ****************************************************
   // Main sequence
   // ****************************************************
   initial
   begin
      n_errors = 0;
      n_tests = 0;
      rst_i = 1'b1;
      req = '0;
      hw_mode = 1'b0;
      sel_pin = 1'b1;
      link_ok = 1'b0;
      hold = 1'b0;
      target = 4'h0;
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(5'h11, 16'h8000);
      rd(5'h01, 16'h0000);
      rd(5'h02, 16'h0000);
      target <= 4'h3;
      repeat (10) @(posedge sys_clk_i);
      rd(5'h11, 16'h9800);
      rd(5'h11, 16'h9800);
      hold <= 1'b1;
      wr(5'h00, 16'h1200);
      wait_restart(8);
      rd(5'h00, 16'h1000);
      rd(5'h11, 16'h9800);
      rd(5'h11, 16'h8000);
      repeat (60) @(posedge sys_clk_i);
      chk({15'h0000, overdue}, 16'h0001);
      hold <= 1'b0;
      target <= 4'h5;
      repeat (10) @(posedge sys_clk_i);
      rd(5'h11, 16'hA800);
      target <= 4'hF;
      link_ok <= 1'b1;
      repeat (16) @(posedge sys_clk_i);
      rd(5'h01, 16'h0024);
      rd(5'h11, 16'hF811);
      rd(5'h11, 16'hC011);
      rd(5'h11, 16'hC011);
      target <= 4'h0;
      link_ok <= 1'b0;
      wait_restart(8);
      wr(5'h00, 16'h0000);
      repeat (3) @(posedge sys_clk_i);
      wr(5'h00, 16'h1000);
      wait_restart(8);
      hw_mode <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      sel_pin <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      sel_pin <= 1'b1;
      wait_restart(12);
      hw_mode <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      wr(5'h00, 16'h8000);
      repeat (4) @(posedge sys_clk_i);
      rd(5'h11, 16'h8000);
      tally_and_finish();
   end
endmodule
